// [logic/cab_pkg.sv]
// Shared constants, register map and state codes of the cabinet controller
package cab_pkg;
  // Timing
  localparam int        CLK_HZ        = 100_000_000;
  localparam int        SEC_PER_MIN   = 60;
  localparam int        SEC_PER_HOUR  = 3600;
  localparam int        WARMUP_S      = 180;
  localparam int        SILENCE_MIN   = 15;
  localparam int        SILENCE_S     = SILENCE_MIN * SEC_PER_MIN;
  localparam int        DECON_TOTAL_H = 3;
  localparam int        DECON_RUN_MIN = 1;
  localparam int        LAMP_LIFE_H   = 5000;
  localparam int        NSTART        = 4;
  localparam logic [15:0] DECON_TOTAL_RST = 16'(DECON_TOTAL_H * SEC_PER_HOUR);
  localparam logic [15:0] DECON_RUN_RST   = 16'(DECON_RUN_MIN * SEC_PER_MIN);
  localparam logic [15:0] START_RST [NSTART] = '{16'h0e10, 16'h1518, 16'h1c20, 16'h2328};
  localparam logic [15:0] WARMUP_CNT      = 16'(WARMUP_S);
  localparam logic [15:0] SILENCE_CNT     = 16'(SILENCE_S);
  localparam logic [19:0] LAMP_LIFE_CNT   = 20'(LAMP_LIFE_H);
  // Register byte offsets
  localparam logic [7:0] OPT_OFS    = 8'h00;
  localparam logic [7:0] PASS_OFS   = 8'h04;
  localparam logic [7:0] TOTAL_OFS  = 8'h08;
  localparam logic [7:0] RUN_OFS    = 8'h0c;
  localparam logic [7:0] START_OFS  = 8'h10;
  localparam logic [7:0] CMD_OFS    = 8'h20;
  localparam logic [7:0] STAT_OFS   = 8'h24;
  localparam logic [7:0] BHRS_OFS   = 8'h28;
  localparam logic [7:0] LHRS_OFS   = 8'h2c;
  localparam logic [7:0] NEXT_OFS   = 8'h30;
  localparam logic [7:0] LEFT_OFS   = 8'h34;
  // Option bits
  localparam int OPT_SYNC_FAN    = 0;
  localparam int OPT_SYNC_LIGHT  = 1;
  localparam int OPT_SYNC_DC     = 2;
  localparam int OPT_SYNC_ACC    = 3;
  localparam int OPT_SYNC_OUTLET = 4;
  localparam int OPT_FLOW_OFF    = 5;
  localparam int OPT_LAMP_ANY    = 6;
  localparam int OPT_WARM_ALARM  = 7;
  localparam int OPT_SILENCE_EN  = 8;
  localparam int OPT_NIGHT_EN    = 9;
  localparam int OPT_AUTO_RST    = 10;
  localparam int OPT_PASS_EN     = 11;
  localparam int OPT_W           = 12;
  localparam logic [11:0] OPT_RST = 12'h500;
  // Decon command bits
  localparam int CMD_GO      = 0;
  localparam int CMD_SEALED  = 1;
  localparam int CMD_GAS     = 2;
  localparam int CMD_STOPPED = 3;
  // Password key codes, first key in the low field
  localparam logic [1:0] KEY_BLOWER = 2'h1;
  localparam logic [1:0] KEY_HIDDEN = 2'h2;
  localparam logic [5:0] PASS_RST   = {KEY_BLOWER, KEY_HIDDEN, KEY_BLOWER};
  localparam logic [1:0] PASS_LAST  = 2'h2;
  typedef enum logic [3:0] {
    BLW_OFF   = 4'h1,
    BLW_WARM  = 4'h2,
    BLW_RUN   = 4'h4,
    BLW_NIGHT = 4'h8
  } blower_state_type;
endpackage : cab_pkg

// [logic/sec_tick.sv]
// One-second tick generator
`timescale 1ns/100ps
`default_nettype none
module sec_tick #(
  parameter int CYCLES = 100_000_000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Tick
  output logic      tick
);
  logic [31:0] count_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else if (count_reg == 32'(CYCLES - 1)) begin
      count_reg <= 32'h0;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h1;
      tick      <= 1'b0;
    end
  end
endmodule : sec_tick
`default_nettype wire

// [logic/hour_meter.sv]
// Running-hours accumulator fed by the second tick
`timescale 1ns/100ps
`default_nettype none
module hour_meter (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        clear,
  // Count
  output logic [19:0]      hours
);
  logic [11:0] secs_reg;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      secs_reg <= 12'h0;
      hours    <= 20'h0;
    end else if (clear) begin
      secs_reg <= 12'h0;
      hours    <= 20'h0;
    end else if (tick && run) begin
      if (secs_reg == 12'(cab_pkg::SEC_PER_HOUR - 1)) begin
        secs_reg <= 12'h0;
        hours    <= hours + 20'h1;
      end else begin
        secs_reg <= secs_reg + 12'h1;
      end
    end
  end
endmodule : hour_meter
`default_nettype wire

// [logic/cabinet_output_interlock_ctrl.sv]
// Cabinet output interlock, alarm, blower and decontamination control
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cabinet_output_interlock_ctrl #(
  parameter int SEC_CYCLES = cab_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Front panel key pulses
  input  wire logic        blower_key,
  input  wire logic        hidden_key,
  input  wire logic        light_key,
  input  wire logic        outlet_key,
  input  wire logic        lamp_key,
  input  wire logic        silence_key,
  // Cabinet sensors
  input  wire logic        sash_closed,
  input  wire logic        airflow_fault,
  input  wire logic        blower_was_running,
  // Power outputs
  output logic             blower_on,
  output logic             blower_low_speed,
  output logic             fan_relay,
  output logic             work_light,
  output logic             dc_out,
  output logic             acc_outlet,
  output logic             outlet_power,
  output logic             germ_lamp,
  // Alarms and indicators
  output logic             alarm_relay,
  output logic             alarm_audible,
  output logic             alarm_visual,
  output logic             blower_led_blink,
  output logic             light_led_blink,
  output logic             overnight_ind,
  output logic             lamp_led_fast,
  output logic             lamp_replace,
  output logic             decon_active,
  output logic             blower_run_mem
);
  localparam int NS = cab_pkg::NSTART;

  function automatic logic is_active(input cab_pkg::blower_state_type s);
    is_active = (s == cab_pkg::BLW_RUN) || (s == cab_pkg::BLW_NIGHT);
  endfunction : is_active

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= cab_pkg::LEFT_OFS);
  endfunction : is_mapped

  cab_pkg::blower_state_type state_reg, state_next;
  logic [11:0] opt_reg;
  logic [5:0]  pass_reg;
  logic [15:0] total_reg, run_reg;
  logic [15:0] start_reg [NS];
  logic [15:0] warm_reg, silence_reg, elapsed_reg;
  logic [1:0]  pass_idx_reg;
  logic        light_reg, outlet_reg, lamp_reg, light_forced_reg;
  logic        boot_reg;
  logic        tick;
  logic [19:0] blower_hours, lamp_hours;
  logic [NS-1:0] in_window;
  logic [15:0] next_s;
  logic [31:0] rdata;
  logic        wr, rd_setup, active, raw_alarm, pass_ok, start_req, decon_go;
  logic [1:0]  key_code;

  sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (tick)
  );

  hour_meter u_blower_hours (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .run      (active),
    .clear    (1'b0),
    .hours    (blower_hours)
  );

  hour_meter u_lamp_hours (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick     (tick),
    .run      (lamp_reg),
    .clear    (wr && paddr == cab_pkg::LHRS_OFS),
    .hours    (lamp_hours)
  );

  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign active   = is_active(state_reg);
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !is_mapped(paddr);

  // Register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_reg   <= cab_pkg::OPT_RST;
      pass_reg  <= cab_pkg::PASS_RST;
      total_reg <= cab_pkg::DECON_TOTAL_RST;
      run_reg   <= cab_pkg::DECON_RUN_RST;
    end else if (wr) begin
      if (paddr == cab_pkg::OPT_OFS) opt_reg <= pwdata[cab_pkg::OPT_W-1:0];
      if (paddr == cab_pkg::PASS_OFS) pass_reg <= pwdata[5:0];
      if (paddr == cab_pkg::TOTAL_OFS) total_reg <= pwdata[15:0];
      if (paddr == cab_pkg::RUN_OFS) run_reg <= pwdata[15:0];
    end
  end

  // Start offsets, one word each
  for (genvar i = 0; i < NS; i++) begin : g_start
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        start_reg[i] <= cab_pkg::START_RST[i];
      end else if (wr && paddr == cab_pkg::START_OFS + 8'(4 * i)) begin
        start_reg[i] <= pwdata[15:0];
      end
    end
    assign in_window[i] = (elapsed_reg >= start_reg[i])
                       && (elapsed_reg < start_reg[i] + run_reg);
  end

  // Read mux; data latched in the setup cycle so it stands through access
  always_comb begin
    rdata = 32'h0;
    unique case (paddr)
      cab_pkg::OPT_OFS:   rdata = {20'h0, opt_reg};
      cab_pkg::PASS_OFS:  rdata = {26'h0, pass_reg};
      cab_pkg::TOTAL_OFS: rdata = {16'h0, total_reg};
      cab_pkg::RUN_OFS:   rdata = {16'h0, run_reg};
      cab_pkg::STAT_OFS:  rdata = {21'h0, silence_reg != 16'h0, decon_active,
                                   lamp_replace, alarm_visual, lamp_reg,
                                   outlet_reg, light_reg, state_reg};
      cab_pkg::BHRS_OFS:  rdata = {12'h0, blower_hours};
      cab_pkg::LHRS_OFS:  rdata = {12'h0, lamp_hours};
      cab_pkg::NEXT_OFS:  rdata = {16'h0, next_s};
      cab_pkg::LEFT_OFS:  rdata = {16'h0, decon_active ? total_reg - elapsed_reg : 16'h0};
      default: begin
        for (int i = 0; i < NS; i++) begin
          if (paddr == cab_pkg::START_OFS + 8'(4 * i)) rdata = {16'h0, start_reg[i]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rdata;
    end
  end

  // Password matching on blower and hidden keys
  assign key_code = blower_key ? cab_pkg::KEY_BLOWER : cab_pkg::KEY_HIDDEN;
  assign pass_ok  = (key_code == pass_reg[2*pass_idx_reg +: 2]);
  assign start_req = blower_key && (!opt_reg[cab_pkg::OPT_PASS_EN]
                  || (pass_ok && pass_idx_reg == cab_pkg::PASS_LAST));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_idx_reg <= 2'h0;
    end else if (state_reg != cab_pkg::BLW_OFF || !opt_reg[cab_pkg::OPT_PASS_EN]) begin
      pass_idx_reg <= 2'h0;
    end else if (blower_key || hidden_key) begin
      if (!pass_ok || pass_idx_reg == cab_pkg::PASS_LAST) pass_idx_reg <= 2'h0;
      else pass_idx_reg <= pass_idx_reg + 2'h1;
    end
  end

  // Restart memory is taken one edge after reset release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // Blower state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cab_pkg::BLW_OFF: begin
        if (boot_reg && blower_was_running && opt_reg[cab_pkg::OPT_AUTO_RST]) begin
          state_next = cab_pkg::BLW_WARM;
        end else if (start_req && !decon_active) begin
          state_next = cab_pkg::BLW_WARM;
        end
      end
      cab_pkg::BLW_WARM: begin
        if (blower_key) state_next = cab_pkg::BLW_OFF;
        else if (tick && warm_reg == 16'h1) state_next = cab_pkg::BLW_RUN;
      end
      cab_pkg::BLW_RUN: begin
        if (blower_key) state_next = cab_pkg::BLW_OFF;
        else if (opt_reg[cab_pkg::OPT_NIGHT_EN] && sash_closed) begin
          state_next = cab_pkg::BLW_NIGHT;
        end
      end
      cab_pkg::BLW_NIGHT: begin
        if (blower_key) state_next = cab_pkg::BLW_OFF;
        else if (!sash_closed || !opt_reg[cab_pkg::OPT_NIGHT_EN]) begin
          state_next = cab_pkg::BLW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cab_pkg::BLW_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Warm-up countdown in seconds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_reg <= 16'h0;
    end else if (state_reg == cab_pkg::BLW_OFF) begin
      warm_reg <= cab_pkg::WARMUP_CNT;
    end else if (tick && warm_reg != 16'h0) begin
      warm_reg <= warm_reg - 16'h1;
    end
  end

  // Work light, outlet and germicidal lamp switches
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      light_reg        <= 1'b0;
      light_forced_reg <= 1'b0;
    end else if (state_reg == cab_pkg::BLW_NIGHT) begin
      light_reg <= 1'b0;
      if (light_reg) light_forced_reg <= 1'b1;
    end else begin
      light_forced_reg <= 1'b0;
      if (light_key) light_reg <= !light_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      outlet_reg <= 1'b0;
    end else if (outlet_key) begin
      outlet_reg <= !outlet_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lamp_reg <= 1'b0;
    end else if (!sash_closed && !opt_reg[cab_pkg::OPT_LAMP_ANY]) begin
      lamp_reg <= 1'b0;
    end else if (lamp_key) begin
      lamp_reg <= !lamp_reg;
    end
  end

  // Alarm conditions
  assign raw_alarm = airflow_fault && !opt_reg[cab_pkg::OPT_FLOW_OFF]
                  && (active || (state_reg == cab_pkg::BLW_WARM
                  && opt_reg[cab_pkg::OPT_WARM_ALARM]));

  // Silence timer; the silence key aborts decon instead while one runs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      silence_reg <= 16'h0;
    end else if (silence_key && raw_alarm && !decon_active
                 && opt_reg[cab_pkg::OPT_SILENCE_EN]) begin
      silence_reg <= cab_pkg::SILENCE_CNT;
    end else if (!raw_alarm) begin
      silence_reg <= 16'h0;
    end else if (tick && silence_reg != 16'h0) begin
      silence_reg <= silence_reg - 16'h1;
    end
  end

  // Decontamination sequence
  assign decon_go = wr && paddr == cab_pkg::CMD_OFS && pwdata[cab_pkg::CMD_GO]
                 && pwdata[cab_pkg::CMD_SEALED] && pwdata[cab_pkg::CMD_GAS]
                 && pwdata[cab_pkg::CMD_STOPPED]
                 && state_reg == cab_pkg::BLW_OFF;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      decon_active <= 1'b0;
      elapsed_reg  <= 16'h0;
    end else if (decon_go && !decon_active) begin
      decon_active <= 1'b1;
      elapsed_reg  <= 16'h0;
    end else if (decon_active) begin
      if (silence_key || elapsed_reg >= total_reg) begin
        decon_active <= 1'b0;
      end else if (tick) begin
        elapsed_reg <= elapsed_reg + 16'h1;
      end
    end
  end

  // Seconds to the nearest start still ahead
  always_comb begin
    next_s = 16'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (decon_active && start_reg[i] > elapsed_reg
          && (next_s == 16'h0 || start_reg[i] - elapsed_reg < next_s)) begin
        next_s = start_reg[i] - elapsed_reg;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      blower_on        <= 1'b0;
      blower_low_speed <= 1'b0;
      fan_relay        <= 1'b0;
      work_light       <= 1'b0;
      dc_out           <= 1'b0;
      acc_outlet       <= 1'b0;
      outlet_power     <= 1'b0;
      germ_lamp        <= 1'b0;
      alarm_relay      <= 1'b0;
      alarm_audible    <= 1'b0;
      alarm_visual     <= 1'b0;
      blower_led_blink <= 1'b0;
      light_led_blink  <= 1'b0;
      overnight_ind    <= 1'b0;
      lamp_led_fast    <= 1'b0;
      lamp_replace     <= 1'b0;
      blower_run_mem   <= 1'b0;
    end else begin
      blower_on        <= state_reg != cab_pkg::BLW_OFF
                       || (decon_active && |in_window);
      blower_low_speed <= state_reg == cab_pkg::BLW_NIGHT;
      fan_relay        <= opt_reg[cab_pkg::OPT_SYNC_FAN] ? active
                       : state_reg != cab_pkg::BLW_OFF;
      work_light       <= light_reg && (active
                       || !opt_reg[cab_pkg::OPT_SYNC_LIGHT]);
      dc_out           <= active || !opt_reg[cab_pkg::OPT_SYNC_DC];
      acc_outlet       <= active || !opt_reg[cab_pkg::OPT_SYNC_ACC];
      outlet_power     <= outlet_reg && (active
                       || !opt_reg[cab_pkg::OPT_SYNC_OUTLET]);
      germ_lamp        <= lamp_reg && (sash_closed
                       || opt_reg[cab_pkg::OPT_LAMP_ANY]);
      alarm_relay      <= raw_alarm;
      alarm_visual     <= raw_alarm;
      alarm_audible    <= raw_alarm && silence_reg == 16'h0;
      blower_led_blink <= state_reg == cab_pkg::BLW_WARM
                       || state_reg == cab_pkg::BLW_NIGHT;
      light_led_blink  <= light_forced_reg;
      overnight_ind    <= state_reg == cab_pkg::BLW_NIGHT;
      lamp_led_fast    <= lamp_hours >= cab_pkg::LAMP_LIFE_CNT;
      lamp_replace     <= lamp_hours >= cab_pkg::LAMP_LIFE_CNT;
      blower_run_mem   <= active;
    end
  end
endmodule : cabinet_output_interlock_ctrl
`default_nettype wire

// [bench/cab_monitor.sv]
// Port checker of the cabinet interlock block
`timescale 1ns/100ps
`default_nettype none
module cab_monitor (
  // Clock, reset and option writes
  input wire logic        core_clk, rst_b, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Watched pins
  input wire logic        sash_closed, blower_on, blower_low_speed, fan_relay, work_light,
  input wire logic        dc_out, germ_lamp, alarm_relay, alarm_audible, alarm_visual,
  input wire logic        blower_led_blink, overnight_ind, lamp_led_fast, lamp_replace
);
  logic [11:0] opt_reg;
  logic        live;
  // Option shadow, so each check knows the mode in force
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_reg <= cab_pkg::OPT_RST;
      live    <= 1'b0;
    end else begin
      live <= 1'b1;
      if (psel && penable && pwrite && paddr == cab_pkg::OPT_OFS) opt_reg <= pwdata[11:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  lamp_start_a: assert property ($rose(germ_lamp) && !opt_reg[6] |->
    $past(sash_closed) || $past(sash_closed, 2)) else $error("lamp lit with sash open");
  lamp_drop_a: assert property ($fell(sash_closed) && !opt_reg[6] |-> ##[1:2] !germ_lamp)
    else $error("lamp stayed on");
  relay_visual_a: assert property (alarm_relay == alarm_visual)
    else $error("alarm relay differs");
  flow_mute_a: assert property (opt_reg[5] && $past(opt_reg[5]) && $past(opt_reg[5], 2) |->
    !(alarm_visual || alarm_audible || alarm_relay)) else $error("alarm while monitor off");
  warm_quiet_a: assert property (blower_led_blink && $past(blower_led_blink) &&
    !blower_low_speed && !opt_reg[7] && !$past(opt_reg[7], 2) |-> !alarm_visual && !alarm_audible)
    else $error("alarm during warm-up");
  night_show_a: assert property (overnight_ind |-> blower_on && blower_low_speed &&
    blower_led_blink) else $error("overnight without low speed");
  night_dark_a: assert property (overnight_ind && $past(overnight_ind) |-> !work_light)
    else $error("light on in overnight");
  dc_default_a: assert property (live && !opt_reg[2] && !$past(opt_reg[2]) |-> dc_out)
    else $error("dc output off");
  pending_off_a: assert property (blower_led_blink && $past(blower_led_blink) &&
    !blower_low_speed && opt_reg[2] && $past(opt_reg[2], 2) |-> !dc_out)
    else $error("synced output on while pending");
  fan_pend_a: assert property (!opt_reg[0] && !$past(opt_reg[0]) && blower_led_blink &&
    $past(blower_led_blink) && !blower_low_speed |-> fan_relay) else $error("fan relay off");
  lamp_flag_a: assert property (lamp_led_fast == lamp_replace)
    else $error("replace flag differs");
endmodule : cab_monitor
bind cabinet_output_interlock_ctrl cab_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sash_closed(sash_closed), .blower_on(blower_on), .blower_low_speed(blower_low_speed),
  .fan_relay(fan_relay), .work_light(work_light), .dc_out(dc_out), .germ_lamp(germ_lamp),
  .alarm_relay(alarm_relay), .alarm_audible(alarm_audible), .alarm_visual(alarm_visual),
  .blower_led_blink(blower_led_blink), .overnight_ind(overnight_ind),
  .lamp_led_fast(lamp_led_fast), .lamp_replace(lamp_replace));
`default_nettype wire

// [bench/panel_model.sv]
// Front panel keypad model
`timescale 1ns/100ps
`default_nettype none
module panel_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Press request
  input  wire logic       press_go,
  input  wire logic [2:0] press_code,
  // Key pulses
  output logic      [5:0] keys
);
  // One key a press, one cycle wide, never two at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) keys <= 6'h0;
    else keys <= press_go ? 6'(1 << press_code) : 6'h0;
  end
endmodule : panel_model
`default_nettype wire

// [bench/cabinet_output_interlock_ctrl_tb.sv]
// Self-checking bench of the cabinet interlock block
`timescale 1ns/100ps
`default_nettype none
module cabinet_output_interlock_ctrl_tb;
  logic core_clk, rst_b, psel, penable, pwrite, press_go, pready, pslverr, er;
  logic sash_closed, airflow_fault, blower_was_running, blower_on, blower_low_speed;
  logic fan_relay, work_light, dc_out, acc_outlet, outlet_power, germ_lamp, alarm_relay;
  logic alarm_audible, alarm_visual, blower_led_blink, light_led_blink, overnight_ind;
  logic decon_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [2:0] press_code;
  logic [5:0] keys;
  int miscompares, check_count, n;
  localparam logic [2:0] BLW = 3'h0, HID = 3'h1, LGT = 3'h2, LMP = 3'h4, SIL = 3'h5;
  panel_model u_panel (.core_clk(core_clk), .rst_b(rst_b), .press_go(press_go),
    .press_code(press_code), .keys(keys));
  cabinet_output_interlock_ctrl #(.SEC_CYCLES(10)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .blower_key(keys[0]),
    .hidden_key(keys[1]), .light_key(keys[2]), .outlet_key(keys[3]), .lamp_key(keys[4]),
    .silence_key(keys[5]), .sash_closed(sash_closed), .airflow_fault(airflow_fault),
    .blower_was_running(blower_was_running), .blower_on(blower_on),
    .blower_low_speed(blower_low_speed), .fan_relay(fan_relay), .work_light(work_light),
    .dc_out(dc_out), .acc_outlet(acc_outlet), .outlet_power(outlet_power),
    .germ_lamp(germ_lamp), .alarm_relay(alarm_relay), .alarm_audible(alarm_audible),
    .alarm_visual(alarm_visual), .blower_led_blink(blower_led_blink),
    .light_led_blink(light_led_blink), .overnight_ind(overnight_ind), .lamp_led_fast(),
    .lamp_replace(), .decon_active(decon_active), .blower_run_mem());
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Synced outputs: off unless the blower runs
  function automatic logic [4:0] sync_exp(input logic [4:0] sync, input logic run);
    return ~sync | {5{run}};
  endfunction : sync_exp
  function automatic logic [31:0] dflt(input int i);
    case (i)
      0: return 32'(cab_pkg::OPT_RST);
      1: return 32'(cab_pkg::PASS_RST);
      2: return 32'(3 * 3600);
      3: return 32'(60);
      default: return 32'(3600 + 1800 * (i - 4));
    endcase
  endfunction : dflt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      miscompares++;
      $display("wrong value at %0t: waited %h limit %h", $time, cnt, lim);
      finish_test();
    end
  endtask : bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    bound(k, 20);
  endtask : apb
  task automatic press(input logic [2:0] c);
    @(posedge core_clk);
    {press_code, press_go} <= {c, 1'b1};
    @(posedge core_clk);
    press_go <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : press
  task automatic opt(input logic [31:0] v);
    apb(1'b1, 8'h00, v);
    repeat (3) @(posedge core_clk);
  endtask : opt
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, press_go, press_code} = '0;
    {sash_closed, airflow_fault, blower_was_running, miscompares, check_count} = '0;
    rnd = 32'hed51;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({dc_out, acc_outlet, blower_on}, 3'b110);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, dflt(i));
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      apb(1'b1, 8'(16 + 4 * i), {16'h0, rnd[15:0]});
      apb(1'b0, 8'(16 + 4 * i), 32'h0);
      chk(rd, {16'h0, rnd[15:0]});
    end
    press(LMP);
    chk(germ_lamp, 1'b0);
    sash_closed <= 1'b1;
    press(LMP);
    chk(germ_lamp, 1'b1);
    sash_closed <= 1'b0;
    press(LGT);
    press(3'h3);
    chk({germ_lamp, work_light, outlet_power}, 3'b011);
    opt(32'h59f);
    chk({outlet_power, acc_outlet, dc_out, work_light, fan_relay}, sync_exp(5'h1f, 1'b0));
    airflow_fault <= 1'b1;
    press(BLW);
    chk({blower_on, blower_led_blink, outlet_power, dc_out, fan_relay}, 5'b11000);
    chk({alarm_visual, alarm_audible, alarm_relay}, 3'b111);
    press(SIL);
    chk({alarm_visual, alarm_audible}, 2'b10);
    for (n = 0; n < 2500 && blower_led_blink !== 1'b0; n++) @(posedge core_clk);
    bound(n, 2500);
    repeat (3) @(posedge core_clk);
    chk({outlet_power, acc_outlet, dc_out, work_light, fan_relay}, sync_exp(5'h1f, 1'b1));
    opt(32'h5bf);
    chk({alarm_visual, alarm_audible, alarm_relay}, 3'b000);
    airflow_fault <= 1'b0;
    opt(32'h700);
    sash_closed <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({overnight_ind, blower_low_speed, work_light, light_led_blink}, 4'b1101);
    press(LGT);
    press(LMP);
    chk({work_light, germ_lamp}, 2'b01);
    repeat (37000) @(posedge core_clk);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h1);
    sash_closed <= 1'b0;
    opt(32'h540);
    press(LMP);
    chk(germ_lamp, 1'b1);
    press(BLW);
    opt(32'hd00);
    airflow_fault <= 1'b1;
    press(HID);
    press(BLW);
    chk(blower_on, 1'b0);
    press(HID);
    press(BLW);
    chk({blower_on, alarm_visual}, 2'b10);
    press(BLW);
    apb(1'b1, 8'h08, 32'h1e);
    apb(1'b1, 8'h0c, 32'h2);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(16 + 4 * i), 32'(5 + 5 * i));
    apb(1'b1, 8'h20, 32'h7);
    repeat (3) @(posedge core_clk);
    chk(decon_active, 1'b0);
    apb(1'b1, 8'h20, 32'hf);
    repeat (3) @(posedge core_clk);
    chk(decon_active, 1'b1);
    for (n = 0; n < 100 && blower_on !== 1'b1; n++) @(posedge core_clk);
    bound(n, 100);
    for (n = 0; n < 100 && blower_on === 1'b1; n++) @(posedge core_clk);
    chk(33'((n + 5) / 10), 33'h2);
    apb(1'b0, 8'h34, 32'h0);
    chk(33'(rd inside {[32'h14:32'h18]}), 33'h1);
    press(SIL);
    chk(decon_active, 1'b0);
    {blower_was_running, rst_b} <= 2'b10;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(blower_on, 1'b1);
    finish_test();
  end
endmodule : cabinet_output_interlock_ctrl_tb
`default_nettype wire
